// *** core/vic_ctrl.v ***
`timescale 1ns/100ps
`include "vic_map.vh"

// Notes on behaviour
// RULE_01: six sources: two pins, four peripherals
// RULE_02: entry clears master enable; others only latch
// RULE_03: stack full blocks acknowledge until return
// RULE_04: entry pushes only program counter, then vectors
// RULE_05: pin edge sets register A bit 4/5
// RULE_06: timer overflow sets register A bit 6
// RULE_07: time-base time-out sets register B bit 4
// RULE_08: conversion done sets register B bit 5
// RULE_09: clock tick sets register B bit 6
// RULE_10: acknowledge clears own flag and master enable
// RULE_11: fixed priority, vectors 004H to 018H
// RULE_12: interrupt return sets master enable; plain not
// RULE_13: requests sampled at each phase two rising edge
// RULE_14: flags hold until serviced or software clears
// RULE_15: service needs master and source enable
// RULE_16: software re-enable inside routine allows nesting
// RULE_17: any pending enabled source requests wake from halt
// RULE_18: registers live at data addresses 0BH, 1EH
// RULE_19: register A bit 0 master, 1-3 enables
// RULE_20: register B bits 0-2 enables; 3,7 zero
// RULE_21: software writes zero to register A bit 7
// RULE_22: no pending enabled source means no redirect
module vic_ctrl (
  input wire sys_clk,
  input wire sys_rst,
  input wire ext_irq_pin_zero,
  input wire ext_irq_pin_one,
  input wire ext0_fall_en,
  input wire ext0_rise_en,
  input wire ext1_fall_en,
  input wire ext1_rise_en,
  input wire timer_overflow,
  input wire timebase_timeout,
  input wire conv_done,
  input wire clock_tick,
  input wire phase_two_clock,
  input wire return_from_irq,
  input wire plain_return,
  input wire [3:0] stack_level_pointer,
  input wire [7:0] dm_addr,
  input wire dm_wr,
  input wire [7:0] dm_wdata,
  output reg [7:0] dm_rdata,
  output reg irq_take,
  output reg [11:0] irq_vector,
  output reg pc_push,
  output reg wake_req
);
  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg [7:0] ctrl_a_d;
  reg [7:0] ctrl_b_d;
  reg phase_prev_q;
  reg [5:0] pend_now;
  reg [5:0] en_now;
  reg [5:0] grant;
  reg [11:0] vec_sel;
  reg [5:0] set_ev;
  wire ext0_lvl;
  wire ext1_lvl;
  wire ext0_edge;
  wire ext1_edge;
  wire stack_full;
  wire phase_rise;
  wire take_now;
  wire sel_a;
  wire sel_b;
  wire any_ready;

  // Pins are asynchronous; two stages before any logic
  // RULE_01 pin synchronisers
  vic_sync2 u_sync0 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(ext_irq_pin_zero),
    .pin_sync(ext0_lvl)
  );

  vic_sync2 u_sync1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(ext_irq_pin_one),
    .pin_sync(ext1_lvl)
  );

  // Idle pin level is high, matching the detector reset
  // RULE_05 selectable edge triggers
  vic_edge_det u_edge0 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(ext0_lvl),
    .fall_en(ext0_fall_en),
    .rise_en(ext0_rise_en),
    .edge_pulse(ext0_edge)
  );

  vic_edge_det u_edge1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level_in(ext1_lvl),
    .fall_en(ext1_fall_en),
    .rise_en(ext1_rise_en),
    .edge_pulse(ext1_edge)
  );

  // Phase two is same-domain logic; find its rising edge
  // A level held high over several cycles counts only once
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_prev_q <= 1'b0;
    end else begin
      phase_prev_q <= phase_two_clock;
    end
  end

  assign phase_rise = phase_two_clock & ~phase_prev_q;

  // Pointer counts used levels; at eight no entry may push
  // RULE_03 stack full detection
  assign stack_full = (stack_level_pointer >= `VIC_STACK_LEVELS);

  // Writes to any other data address leave both registers alone
  // RULE_18 address decode
  assign sel_a = dm_wr & (dm_addr == `VIC_ADDR_CTRL_A);
  assign sel_b = dm_wr & (dm_addr == `VIC_ADDR_CTRL_B);

  // Source event vector, priority order
  // Peripheral pulses are same-clock; no synchroniser needed
  // Pin edges lag the pins by two clocks
  always @* begin
    set_ev = {clock_tick, conv_done, timebase_timeout, timer_overflow, ext1_edge, ext0_edge};
  end

  // Current pending and enable vectors, priority order
  // Bit k of both vectors is the source of priority k+1
  always @* begin
    pend_now = {ctrl_b_q[`VIC_B_TICK_PEND], ctrl_b_q[`VIC_B_CONV_PEND],
                ctrl_b_q[`VIC_B_TB_PEND], ctrl_a_q[`VIC_A_TIMER_PEND],
                ctrl_a_q[`VIC_A_EXT1_PEND], ctrl_a_q[`VIC_A_EXT0_PEND]};
    en_now = {ctrl_b_q[`VIC_B_TICK_EN], ctrl_b_q[`VIC_B_CONV_EN],
              ctrl_b_q[`VIC_B_TB_EN], ctrl_a_q[`VIC_A_TIMER_EN],
              ctrl_a_q[`VIC_A_EXT1_EN], ctrl_a_q[`VIC_A_EXT0_EN]};
  end

  // Some source both pending and enabled
  assign any_ready = |(pend_now & en_now);

  // A refused request keeps its flag and retries at a later phase
  // RULE_15 both enables needed; RULE_16 nesting falls out of it
  // RULE_13 acknowledge only at phase two rising edge
  assign take_now = phase_rise & ctrl_a_q[`VIC_A_MASTER_EN] & ~stack_full &
                    any_ready;

  // Grant stays empty unless the take happens at this very edge
  // RULE_11 fixed priority grant and vector
  always @* begin
    grant = 6'h00;
    vec_sel = `VIC_VEC_NONE;
    if (pend_now[0] & en_now[0]) begin
      grant = 6'h01;
      vec_sel = `VIC_VEC_EXT0;
    end else if (pend_now[1] & en_now[1]) begin
      grant = 6'h02;
      vec_sel = `VIC_VEC_EXT1;
    end else if (pend_now[2] & en_now[2]) begin
      grant = 6'h04;
      vec_sel = `VIC_VEC_TIMER;
    end else if (pend_now[3] & en_now[3]) begin
      grant = 6'h08;
      vec_sel = `VIC_VEC_TB;
    end else if (pend_now[4] & en_now[4]) begin
      grant = 6'h10;
      vec_sel = `VIC_VEC_CONV;
    end else if (pend_now[5] & en_now[5]) begin
      grant = 6'h20;
      vec_sel = `VIC_VEC_TICK;
    end
    if (!take_now) begin
      grant = 6'h00;
    end
  end

  // Next value of register A
  // Later assignments win: return, then clears, then hardware sets
  always @* begin
    ctrl_a_d = ctrl_a_q;
    // Bit 7 kept as written; software has to leave it zero
    // RULE_19 software write, all eight bits stored
    if (sel_a) begin
      ctrl_a_d = dm_wdata;
    end
    // RULE_12 interrupt return restores master enable
    if (return_from_irq) begin
      ctrl_a_d[`VIC_A_MASTER_EN] = 1'b1;
    end
    // RULE_10 acknowledge clears own flag
    if (grant[0]) begin
      ctrl_a_d[`VIC_A_EXT0_PEND] = 1'b0;
    end
    if (grant[1]) begin
      ctrl_a_d[`VIC_A_EXT1_PEND] = 1'b0;
    end
    if (grant[2]) begin
      ctrl_a_d[`VIC_A_TIMER_PEND] = 1'b0;
    end
    // RULE_02 entry clears master enable
    if (take_now) begin
      ctrl_a_d[`VIC_A_MASTER_EN] = 1'b0;
    end
    // RULE_05 RULE_06 events win over clears
    if (set_ev[0]) begin
      ctrl_a_d[`VIC_A_EXT0_PEND] = 1'b1;
    end
    if (set_ev[1]) begin
      ctrl_a_d[`VIC_A_EXT1_PEND] = 1'b1;
    end
    if (set_ev[2]) begin
      ctrl_a_d[`VIC_A_TIMER_PEND] = 1'b1;
    end
  end

  // Next value of register B
  // Later assignments win, so an event beats a clear
  always @* begin
    ctrl_b_d = ctrl_b_q;
    // RULE_20 unused bits never stored
    if (sel_b) begin
      ctrl_b_d = dm_wdata & `VIC_B_WMASK;
    end
    // RULE_10 acknowledge clears own flag
    if (grant[3]) begin
      ctrl_b_d[`VIC_B_TB_PEND] = 1'b0;
    end
    if (grant[4]) begin
      ctrl_b_d[`VIC_B_CONV_PEND] = 1'b0;
    end
    if (grant[5]) begin
      ctrl_b_d[`VIC_B_TICK_PEND] = 1'b0;
    end
    // RULE_07 RULE_08 RULE_09 events win over clears
    if (set_ev[3]) begin
      ctrl_b_d[`VIC_B_TB_PEND] = 1'b1;
    end
    if (set_ev[4]) begin
      ctrl_b_d[`VIC_B_CONV_PEND] = 1'b1;
    end
    if (set_ev[5]) begin
      ctrl_b_d[`VIC_B_TICK_PEND] = 1'b1;
    end
  end

  // No automatic clear elsewhere; flags survive masking
  // RULE_14 flags held in registers until cleared
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_a_q <= `VIC_A_RESET;
      ctrl_b_q <= `VIC_B_RESET;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // Registered outputs toward the core sequencer
  // Take, push and vector rise together for one cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_take <= 1'b0;
      pc_push <= 1'b0;
      irq_vector <= `VIC_VEC_NONE;
      wake_req <= 1'b0;
      dm_rdata <= 8'h00;
    end else begin
      // RULE_04 push program counter, then branch
      // RULE_22 no take leaves vector idle
      irq_take <= take_now;
      pc_push <= take_now;
      irq_vector <= take_now ? vec_sel : `VIC_VEC_NONE;
      // Master enable ignored so a halted core still wakes
      // RULE_17 any pending enabled source wakes
      wake_req <= any_ready;
      // Read data lags the address by one cycle
      // Read mux; other addresses answer zero
      if (dm_addr == `VIC_ADDR_CTRL_A) begin
        dm_rdata <= ctrl_a_q;
      end else if (dm_addr == `VIC_ADDR_CTRL_B) begin
        dm_rdata <= ctrl_b_q;
      end else begin
        dm_rdata <= 8'h00;
      end
    end
  end

  // Kept only so the port has a reader
  // RULE_12 plain return has no effect here
  wire unused_ret;
  assign unused_ret = plain_return;
endmodule // vic_ctrl

// *** core/vic_edge_det.v ***
`timescale 1ns/100ps
// Edge detector with selectable falling and rising trigger
module vic_edge_det (
  input wire sys_clk,
  input wire sys_rst,
  input wire level_in,
  input wire fall_en,
  input wire rise_en,
  output wire edge_pulse
);
  reg prev_q;

  // Delayed copy of synchronised level
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level_in;
    end
  end

  assign edge_pulse = (fall_en & prev_q & ~level_in) | (rise_en & ~prev_q & level_in);
endmodule // vic_edge_det

// *** core/vic_map.vh ***
`ifndef VIC_MAP_VH
`define VIC_MAP_VH
// Data-memory addresses of the two control registers
`define VIC_ADDR_CTRL_A 8'h0B
`define VIC_ADDR_CTRL_B 8'h1E
// Register A fields
`define VIC_A_MASTER_EN 0
`define VIC_A_EXT0_EN 1
`define VIC_A_EXT1_EN 2
`define VIC_A_TIMER_EN 3
`define VIC_A_EXT0_PEND 4
`define VIC_A_EXT1_PEND 5
`define VIC_A_TIMER_PEND 6
`define VIC_A_TEST_BIT 7
// Register B fields
`define VIC_B_TB_EN 0
`define VIC_B_CONV_EN 1
`define VIC_B_TICK_EN 2
`define VIC_B_TB_PEND 4
`define VIC_B_CONV_PEND 5
`define VIC_B_TICK_PEND 6
// Reset values and writable mask of register B
`define VIC_A_RESET 8'h00
`define VIC_B_RESET 8'h00
`define VIC_B_WMASK 8'h77
// Vectors, priority 1 to 6
`define VIC_VEC_EXT0 12'h004
`define VIC_VEC_EXT1 12'h008
`define VIC_VEC_TIMER 12'h00C
`define VIC_VEC_TB 12'h010
`define VIC_VEC_CONV 12'h014
`define VIC_VEC_TICK 12'h018
`define VIC_VEC_NONE 12'h000
// Stack depth
`define VIC_STACK_LEVELS 4'h8
`endif

// *** core/vic_sync2.v ***
`timescale 1ns/100ps
// Two-stage synchroniser for a pin level
module vic_sync2 (
  input wire sys_clk,
  input wire sys_rst,
  input wire pin_in,
  output wire pin_sync
);
  reg meta_q;
  reg sync_q;

  // First stage read only by second
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule // vic_sync2

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// Bench for the interrupt controller
module testbench;
  reg sys_clk = 1'h0;
  reg sys_rst = 1'h1;
  reg pin0 = 1'h1;
  reg pin1 = 1'h1;
  reg [3:0] esel = 4'h9;
  reg wr = 1'h0;
  reg sp_ld = 1'h0;
  reg [3:0] sp_val = 4'h0;
  reg [5:0] ev = 6'h00;
  reg [7:0] addr = 8'h30;
  reg [7:0] wdata = 8'h00;
  reg [7:0] r;
  reg [11:0] exp_q[$];
  wire ph2, take, push, wake;
  wire [3:0] sp;
  wire [7:0] rdata;
  wire [11:0] vec;
  integer num_errors = 0;
  integer checked = 0;
  integer i;
  integer n;
  initial forever #12.5 sys_clk = ~sys_clk;
  vic_ctrl u_vic_ctrl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
    .ext0_fall_en(esel[0]), .ext0_rise_en(esel[1]), .ext1_fall_en(esel[2]),
    .ext1_rise_en(esel[3]),
    .timer_overflow(ev[0]), .timebase_timeout(ev[1]), .conv_done(ev[2]), .clock_tick(ev[3]),
    .phase_two_clock(ph2), .return_from_irq(ev[4]), .plain_return(ev[5]),
    .stack_level_pointer(sp), .dm_addr(addr), .dm_wr(wr), .dm_wdata(wdata), .dm_rdata(rdata),
    .irq_take(take), .irq_vector(vec), .pc_push(push), .wake_req(wake));
  vic_core_model u_vic_core_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pc_push(push), .ret_pulse(ev[4] | ev[5]),
    .sp_ld(sp_ld), .sp_val(sp_val), .phase_two_clock(ph2), .stack_level_pointer(sp));
  task check(input [11:0] got, input [11:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk) {addr, wdata, wr} = {a, d, 1'h1};
      @(negedge sys_clk) wr = 1'h0;
    end
  endtask
  task rd_reg(input [7:0] a, input [7:0] e);
    begin
      @(negedge sys_clk) addr = a;
      @(negedge sys_clk) check({4'h0, rdata}, {4'h0, e});
    end
  endtask
  task pulse_ev(input [5:0] m);
    begin
      @(negedge sys_clk) ev = m;
      @(negedge sys_clk) ev = 6'h00;
    end
  endtask
  task set_sp(input [3:0] v);
    begin
      @(negedge sys_clk) {sp_val, sp_ld} = {v, 1'h1};
      @(negedge sys_clk) sp_ld = 1'h0;
    end
  endtask
  task wait_q;
    begin
      for (n = 0; n < 40 && exp_q.size() != 0; n = n + 1)
        @(negedge sys_clk);
      if (exp_q.size() != 0) begin
        check(12'h000, 12'hFFF);
        finish_test;
      end
    end
  endtask
  // Each acknowledge against the oldest note
  always @(negedge sys_clk) begin
    if (take === 1'h1) begin
      check(vec, exp_q.size() != 0 ? exp_q.pop_front() : 12'hFFF);
      check({11'h000, push}, 12'h001);
    end
  end
  // Main sequence
  initial begin
    r = $urandom(66602);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'h0;
    rd_reg(8'h0B, 8'h00);
    rd_reg(8'h1E, 8'h00);
    wr_reg(8'h1E, r);
    rd_reg(8'h1E, r & 8'h77);
    wr_reg(8'h0B, r & 8'h0E);
    wr_reg(8'h0C, 8'hFF);
    rd_reg(8'h0B, r & 8'h0E);
    $display("test 1 done");
    wr_reg(8'h0B, 8'h0E);
    wr_reg(8'h1E, 8'h07);
    {pin0, pin1} = 2'h0;
    pulse_ev(6'h0F);
    repeat (4) @(negedge sys_clk);
    {pin0, pin1} = 2'h3;
    repeat (8) @(negedge sys_clk);
    rd_reg(8'h0B, 8'h7E);
    rd_reg(8'h1E, 8'h77);
    check({11'h000, wake}, 12'h001);
    $display("test 2 done");
    wr_reg(8'h0B, 8'h7F);
    for (i = 1; i <= 6; i = i + 1) begin
      exp_q.push_back(12'(4 * i));
      wait_q;
      pulse_ev(6'h10);
    end
    rd_reg(8'h0B, 8'h0F);
    rd_reg(8'h1E, 8'h07);
    $display("test 3 done");
    set_sp(4'h8);
    pulse_ev(6'h01);
    repeat (12) @(negedge sys_clk);
    exp_q.push_back(12'h00C);
    set_sp(4'h7);
    wait_q;
    $display("test 4 done");
    pulse_ev(6'h20);
    pulse_ev(6'h04);
    repeat (12) @(negedge sys_clk);
    rd_reg(8'h0B, 8'h0E);
    rd_reg(8'h1E, 8'h27);
    exp_q.push_back(12'h014);
    wr_reg(8'h0B, 8'h0F);
    wait_q;
    $display("test 5 done");
    // Opposite edge selection on both pins
    esel = 4'h6;
    {pin0, pin1} = 2'h0;
    repeat (8) @(negedge sys_clk);
    {pin0, pin1} = 2'h3;
    repeat (8) @(negedge sys_clk);
    rd_reg(8'h0B, 8'h3E);
    wr_reg(8'h0B, 8'h0E);
    rd_reg(8'h0B, 8'h0E);
    check({11'h000, wake}, 12'h000);
    $display("test 6 done");
    finish_test;
  end
endmodule // testbench

// *** tb/vic_core_model.sv ***
`timescale 1ns/100ps
// Core sequencer: phase two and stack level
module vic_core_model (
  input wire sys_clk,
  input wire sys_rst,
  input wire pc_push,
  input wire ret_pulse,
  input wire sp_ld,
  input wire [3:0] sp_val,
  output reg phase_two_clock = 1'h0,
  output reg [3:0] stack_level_pointer = 4'h0
);
  reg [1:0] ph_q = 2'h0;
  // phase two
  // Phase two high one clock in four
  always @(posedge sys_clk) begin
    ph_q <= sys_rst ? 2'h0 : ph_q + 2'h1;
    phase_two_clock <= !sys_rst && ph_q == 2'h1;
  end
  // push and pop
  // Stack level follows entries and returns
  always @(posedge sys_clk) begin
    if (sys_rst || sp_ld)
      stack_level_pointer <= sys_rst ? 4'h0 : sp_val;
    else
      stack_level_pointer <= stack_level_pointer + {3'h0, pc_push} - {3'h0, ret_pulse};
  end
endmodule // vic_core_model

// *** tb/vic_properties.sv ***
`timescale 1ns/100ps
// Port checks of the interrupt controller
module vic_properties (
  input wire sys_clk,
  input wire sys_rst,
  input wire phase_two_clock,
  input wire return_from_irq,
  input wire [3:0] stack_level_pointer,
  input wire [7:0] dm_addr,
  input wire dm_wr,
  input wire [7:0] dm_rdata,
  input wire irq_take,
  input wire [11:0] irq_vector,
  input wire pc_push,
  input wire wake_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // No return and no register write
  sequence s_quiet;
    (!return_from_irq && !dm_wr)[*3];
  endsequence
  AST_PUSH: assert property (irq_take == pc_push)
    else $error("push differs");
  AST_PHASE: assert property (
    irq_take |-> $past(phase_two_clock) && !$past(phase_two_clock, 2))
    else $error("take off phase");
  AST_FULL: assert property (irq_take |-> $past(stack_level_pointer) < 4'h8)
    else $error("take on full stack");
  AST_VEC: assert property (
    irq_take |-> irq_vector inside {12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018})
    else $error("bad vector");
  AST_IDLE: assert property (!irq_take |-> irq_vector == 12'h000)
    else $error("vector while idle");
  AST_BLOCK: assert property (irq_take ##1 s_quiet |=> !irq_take)
    else $error("take while blocked");
  AST_WAKE: assert property (irq_take |-> wake_req || $past(wake_req))
    else $error("no wake");
  AST_RDZ: assert property (
    dm_addr != 8'h0B && dm_addr != 8'h1E |=> dm_rdata == 8'h00)
    else $error("read elsewhere");
  AST_RDB: assert property (dm_addr == 8'h1E |=> (dm_rdata & 8'h88) == 8'h00)
    else $error("unused bits set");
endmodule // vic_properties

bind vic_ctrl vic_properties u_vic_properties (
  .sys_clk, .sys_rst, .phase_two_clock, .return_from_irq, .stack_level_pointer,
  .dm_addr, .dm_wr, .dm_rdata, .irq_take, .irq_vector, .pc_push, .wake_req);
